//--- src/pdm_regs.svh
// Register offsets, field values, reset values and limits of the monitor.
// Assumes a plain strobe port with read data one cycle after the strobe.
// Behaviour
// - Deviation limit accepts 1..30000 in 0.02 rev units, default 150.
// - Gap above the active limit raises the deviation alarm, code 10h.
// - A written limit is only read back; the active limit stays at default 150.
// - Hold polarity 0 acts on input on, 1 acts on input off; default 0.
// - Command position is signed, floor -8388608, readable at any time.
// - Position writes are accepted only while stopped and energized.
// - Position is not kept; reloads default at power-up and alarm reset.
// - Limit is read and write; hold polarity is write only.
`ifndef PDM_REGS_SVH
`define PDM_REGS_SVH

`define PDM_ADDR_W 4
`define PDM_OFF_LIMIT 4'h0
`define PDM_OFF_POLARITY 4'h1
`define PDM_OFF_POSITION 4'h2
`define PDM_OFF_ALARM 4'h3
`define PDM_OFF_STATUS 4'h4
`define PDM_OFF_MASK 4'h5
`define PDM_OFF_CONTROL 4'h6

`define PDM_LIMIT_MIN 15'h0001
`define PDM_LIMIT_MAX 15'h7530
`define PDM_LIMIT_DEF 15'h0096
`define PDM_POL_DEF 1'h0
`define PDM_POS_DEF 24'h000000
`define PDM_POS_MIN 24'h800000
`define PDM_POS_MAX 24'h7fffff
`define PDM_ALARM_DEVIATION 8'h10
`define PDM_ALARM_NONE 8'h00

`define PDM_ST_ALARM 0
`define PDM_ST_REJECT 1
`define PDM_ST_LIMIT_BAD 2
`define PDM_ST_W 3

`endif

//--- src/pdm_pkg.sv
// Types shared by the deviation monitor modules.
// Assumes pdm_regs.svh supplies the widths.
`include "pdm_regs.svh"
package pdm_pkg;
  typedef logic [23:0] pdm_pos_t;
  typedef logic [14:0] pdm_limit_t;
  typedef enum logic [2:0] {
    PDM_IDLE = 3'h1,
    PDM_ALARM = 3'h2,
    PDM_CLEAR = 3'h4
  } pdm_state_t;
endpackage

//--- src/pdm_pos_counter.sv
// Signed command position counter with saturating step moves.
// Assumes the parent gates load requests by motor state.
`include "pdm_regs.svh"
module pdm_pos_counter (
  input wire logic mclk,
  input wire logic resetn,
  input wire logic ce,
  input wire logic step,
  input wire logic dir_neg,
  input wire logic load,
  input wire logic [23:0] load_value,
  input wire logic reload,
  output pdm_pkg::pdm_pos_t count
);
  pdm_pkg::pdm_pos_t count_reg;
  pdm_pkg::pdm_pos_t count_next;

  always_comb begin
    count_next = count_reg;
    if (reload) begin
      count_next = `PDM_POS_DEF;
    end else if (load) begin
      count_next = load_value;
    end else if (step) begin
      if (dir_neg && count_reg != `PDM_POS_MIN) begin
        count_next = count_reg - 24'h000001;
      end else if (!dir_neg && count_reg != `PDM_POS_MAX) begin
        count_next = count_reg + 24'h000001;
      end
    end
  end

  always_ff @(posedge mclk) begin
    if (!resetn) begin
      count_reg <= `PDM_POS_DEF;
    end else if (ce) begin
      count_reg <= count_next;
    end
  end

  assign count = count_reg;

  property p_floor;
    @(posedge mclk) disable iff (!resetn)
      (ce && step && dir_neg && !load && !reload &&
       count_reg == `PDM_POS_MIN) |=> count_reg == `PDM_POS_MIN;
  endproperty
  a_floor: assert property (p_floor)
    else $error("position went below floor");

  property p_step;
    @(posedge mclk) disable iff (!resetn)
      (ce && step && !dir_neg && !load && !reload &&
       count_reg != `PDM_POS_MAX) |=> count_reg == $past(count_reg) + 1;
  endproperty
  a_step: assert property (p_step)
    else $error("step did not advance position");
endmodule

//--- src/pdm_deviation_check.sv
// Magnitude compare of commanded versus actual position against a limit.
// Assumes positions in steps and limit already scaled to steps.
module pdm_deviation_check (
  input wire logic mclk,
  input wire logic resetn,
  input wire logic ce,
  input wire logic [23:0] cmd_pos,
  input wire logic [23:0] act_pos,
  input wire logic [31:0] limit_steps,
  output logic over
);
  logic over_reg;
  logic over_next;
  logic signed [24:0] diff;
  logic [24:0] mag;

  always_comb begin
    diff = $signed({cmd_pos[23], cmd_pos}) - $signed({act_pos[23], act_pos});
    mag = diff[24] ? 25'(-diff) : 25'(diff);
    over_next = {7'h00, mag} > limit_steps;
  end

  always_ff @(posedge mclk) begin
    if (!resetn) begin
      over_reg <= 1'h0;
    end else if (ce) begin
      over_reg <= over_next;
    end
  end

  assign over = over_reg;
endmodule

//--- src/pdm_top.sv
// Top of the position deviation monitor: registers, alarm, hold logic.
// Assumes synchronous inputs on mclk and a non-waiting strobe master.
`include "pdm_regs.svh"
module pdm_top #(
  parameter int STEPS_PER_REV = 500
) (
  input wire logic mclk,
  input wire logic resetn,
  input wire logic ce,
  input wire logic [3:0] addr,
  input wire logic [31:0] wdata,
  input wire logic wr_en,
  input wire logic rd_en,
  output logic [31:0] rdata,
  input wire logic step,
  input wire logic dir_neg,
  input wire logic motor_stopped,
  input wire logic motor_energized,
  input wire logic [23:0] act_pos,
  input wire logic hold_input,
  input wire logic alarm_clear_input,
  output logic hold_active,
  output logic [7:0] alarm_code_read,
  output logic alarm_active,
  output logic irq
);
  // Limit written by software is kept here for read-back only; reset reloads the default.
  pdm_pkg::pdm_limit_t limit_store_reg, limit_store_next;
  pdm_pkg::pdm_limit_t limit_active_reg, limit_active_next;
  logic hold_input_polarity_reg, hold_input_polarity_next;
  logic [`PDM_ST_W-1:0] status_reg, status_next;
  logic [`PDM_ST_W-1:0] mask_reg, mask_next;
  logic [31:0] rdata_reg, rdata_next;
  logic [7:0] alarm_code_reg, alarm_code_next;
  pdm_pkg::pdm_state_t state_reg, state_next;
  pdm_pkg::pdm_pos_t cmd_position_count;
  logic pos_load, pos_reload, over, alarm_clear_cmd;
  logic [31:0] limit_steps;

  function automatic logic sel(input logic [3:0] a, input logic [3:0] off);
    sel = (a == off);
  endfunction

  assign alarm_clear_cmd = wr_en && sel(addr, `PDM_OFF_CONTROL) && wdata[0];
  assign pos_load = wr_en && sel(addr, `PDM_OFF_POSITION) &&
                    motor_stopped && motor_energized;
  assign pos_reload = (state_reg == pdm_pkg::PDM_CLEAR);
  // 0.02 rev = steps/50; rounded down, so small limits are strict
  assign limit_steps = (32'(limit_active_reg) * 32'(STEPS_PER_REV)) /
                       32'd50;

  pdm_pos_counter u_pos (
    .mclk(mclk),
    .resetn(resetn),
    .ce(ce),
    .step(step && state_reg == pdm_pkg::PDM_IDLE),
    .dir_neg(dir_neg),
    .load(pos_load),
    .load_value(wdata[23:0]),
    .reload(pos_reload),
    .count(cmd_position_count)
  );

  pdm_deviation_check u_dev (
    .mclk(mclk),
    .resetn(resetn),
    .ce(ce),
    .cmd_pos(cmd_position_count),
    .act_pos(act_pos),
    .limit_steps(limit_steps),
    .over(over)
  );

  always_comb begin
    limit_store_next = limit_store_reg;
    limit_active_next = limit_active_reg;
    hold_input_polarity_next = hold_input_polarity_reg;
    mask_next = mask_reg;
    status_next = status_reg;
    state_next = state_reg;
    alarm_code_next = alarm_code_reg;
    rdata_next = 32'h00000000;
    if (wr_en) begin
      case (addr)
        `PDM_OFF_LIMIT: begin
          if (wdata[31:0] >= 32'(`PDM_LIMIT_MIN) &&
              wdata[31:0] <= 32'(`PDM_LIMIT_MAX)) begin
            limit_store_next = wdata[14:0];
          end else begin
            status_next[`PDM_ST_LIMIT_BAD] = 1'h1;
          end
        end
        `PDM_OFF_POLARITY: hold_input_polarity_next = wdata[0];
        `PDM_OFF_POSITION: begin
          if (!pos_load) begin
            status_next[`PDM_ST_REJECT] = 1'h1;
          end
        end
        `PDM_OFF_STATUS: status_next = status_reg & ~wdata[`PDM_ST_W-1:0];
        `PDM_OFF_MASK: mask_next = wdata[`PDM_ST_W-1:0];
        default: begin
        end
      endcase
      // Events in the clear cycle survive
      if (sel(addr, `PDM_OFF_LIMIT) && !(wdata[31:0] >=
          32'(`PDM_LIMIT_MIN) && wdata[31:0] <= 32'(`PDM_LIMIT_MAX))) begin
        status_next[`PDM_ST_LIMIT_BAD] = 1'h1;
      end
      if (sel(addr, `PDM_OFF_POSITION) && !pos_load) begin
        status_next[`PDM_ST_REJECT] = 1'h1;
      end
    end
    case (state_reg)
      pdm_pkg::PDM_IDLE: begin
        if (over) begin
          state_next = pdm_pkg::PDM_ALARM;
          alarm_code_next = `PDM_ALARM_DEVIATION;
          status_next[`PDM_ST_ALARM] = 1'h1;
        end
      end
      pdm_pkg::PDM_ALARM: begin
        if (alarm_clear_cmd || alarm_clear_input) begin
          state_next = pdm_pkg::PDM_CLEAR;
        end
      end
      pdm_pkg::PDM_CLEAR: begin
        state_next = pdm_pkg::PDM_IDLE;
        alarm_code_next = `PDM_ALARM_NONE;
      end
      default: state_next = pdm_pkg::PDM_IDLE;
    endcase
    if (rd_en) begin
      case (addr)
        `PDM_OFF_LIMIT: rdata_next = {17'h00000, limit_store_reg};
        `PDM_OFF_POSITION: begin
          rdata_next = {{8{cmd_position_count[23]}},
                        cmd_position_count};
        end
        `PDM_OFF_ALARM: rdata_next = {24'h000000, alarm_code_reg};
        `PDM_OFF_STATUS: rdata_next = {29'h00000000, status_reg};
        `PDM_OFF_MASK: rdata_next = {29'h00000000, mask_reg};
        default: rdata_next = 32'h00000000;
      endcase
    end
  end

  always_ff @(posedge mclk) begin
    if (!resetn) begin
      limit_store_reg <= `PDM_LIMIT_DEF;
      limit_active_reg <= `PDM_LIMIT_DEF;
      hold_input_polarity_reg <= `PDM_POL_DEF;
      status_reg <= '0;
      mask_reg <= '0;
      rdata_reg <= 32'h00000000;
      alarm_code_reg <= `PDM_ALARM_NONE;
      state_reg <= pdm_pkg::PDM_IDLE;
    end else if (ce) begin
      limit_store_reg <= limit_store_next;
      limit_active_reg <= limit_active_next;
      hold_input_polarity_reg <= hold_input_polarity_next;
      status_reg <= status_next;
      mask_reg <= mask_next;
      rdata_reg <= rdata_next;
      alarm_code_reg <= alarm_code_next;
      state_reg <= state_next;
    end
  end

  // Power-up is modelled by resetn: stored limit is lost too, as no NVRAM
  logic limit_armed_reg;
  always_ff @(posedge mclk) begin
    if (!resetn) begin
      limit_armed_reg <= 1'h0;
    end else begin
      limit_armed_reg <= 1'h1;
    end
  end

  assign rdata = rdata_reg;
  assign hold_active = hold_input ^ hold_input_polarity_reg;
  assign alarm_code_read = alarm_code_reg;
  assign alarm_active = (state_reg == pdm_pkg::PDM_ALARM);
  assign irq = |(status_reg & mask_reg);

  property p_limit_fixed;
    @(posedge mclk) disable iff (!resetn)
      limit_armed_reg |=> $stable(limit_active_reg);
  endproperty
  a_limit_fixed: assert property (p_limit_fixed)
    else $error("active limit changed without power cycle");

  property p_alarm;
    @(posedge mclk) disable iff (!resetn)
      (ce && over && state_reg == pdm_pkg::PDM_IDLE) |=>
        (alarm_code_read == 8'h10 && alarm_active);
  endproperty
  a_alarm: assert property (p_alarm)
    else $error("deviation alarm not raised");

  property p_reject;
    @(posedge mclk) disable iff (!resetn)
      (ce && wr_en && addr == `PDM_OFF_POSITION && !motor_stopped &&
       !pos_reload) |=> $stable(cmd_position_count) || $past(step);
  endproperty
  a_reject: assert property (p_reject)
    else $error("position written while moving");

  property p_clear;
    @(posedge mclk) disable iff (!resetn)
      (ce && state_reg == pdm_pkg::PDM_CLEAR) |=> cmd_position_count == 0;
  endproperty
  a_clear: assert property (p_clear)
    else $error("position not reloaded on alarm reset");

  property p_range;
    @(posedge mclk) disable iff (!resetn)
      limit_store_reg >= 15'h0001 && limit_store_reg <= 15'h7530;
  endproperty
  a_range: assert property (p_range)
    else $error("stored limit out of range");

  property p_pol_read;
    @(posedge mclk) disable iff (!resetn)
      (ce && rd_en && addr == `PDM_OFF_POLARITY) |=> rdata == 0;
  endproperty
  a_pol_read: assert property (p_pol_read)
    else $error("polarity readable");

  property p_hold;
    @(posedge mclk) disable iff (!resetn)
      hold_active == (hold_input != hold_input_polarity_reg);
  endproperty
  a_hold: assert property (p_hold)
    else $error("hold polarity wrong");

  property p_posread;
    @(posedge mclk) disable iff (!resetn)
      (ce && rd_en && addr == `PDM_OFF_POSITION) |=>
        rdata[23:0] == $past(cmd_position_count);
  endproperty
  a_posread: assert property (p_posread)
    else $error("position read mismatch");
endmodule

//--- dv/pdm_motor_model.sv
// Motor-side model: the shaft follows commanded steps, offset by lag.
// Assumes step and dir_neg change just after rising mclk.
module pdm_motor_model (
  input wire logic mclk,
  input wire logic resetn,
  input wire logic step,
  input wire logic dir_neg,
  input wire logic [23:0] lag,
  output logic [23:0] act_pos
);
  logic [23:0] act_reg;
  logic [23:0] act_next;
  // Wraps freely: a real shaft has no end stop
  always_comb begin
    act_next = act_reg;
    if (step) begin
      act_next = dir_neg ? act_reg - 24'h000001 : act_reg + 24'h000001;
    end
  end
  always_ff @(posedge mclk) begin
    if (!resetn) begin
      act_reg <= 24'h000000;
    end else begin
      act_reg <= act_next;
    end
  end
  assign act_pos = act_reg - lag;
endmodule

//--- dv/tb.sv
// Self-checking bench for the deviation monitor and its register port.
// Assumes STEPS_PER_REV of 50, so one limit unit equals one step.
`include "pdm_regs.svh"
module tb;
  timeunit 1ns;
  timeprecision 100ps;
  logic mclk = 1'b0;
  logic resetn = 1'b0;
  logic ce = 1'b1;
  logic [3:0] addr = 4'h0;
  logic [31:0] wdata = 32'h00000000;
  logic wr_en = 1'b0;
  logic rd_en = 1'b0;
  logic step = 1'b0;
  logic dir_neg = 1'b0;
  logic stopped = 1'b1;
  logic energized = 1'b1;
  logic hold_in = 1'b0;
  logic clr_in = 1'b0;
  logic [23:0] lag = 24'h000000;
  logic [31:0] rdata;
  logic [23:0] act_pos;
  logic hold_active;
  logic alarm_active;
  logic irq;
  logic [7:0] alarm_code;
  logic rd_seen = 1'b0;
  logic [31:0] exp_q[$];
  int fail_count = 0;
  int tests_run = 0;
  int n;

  initial begin
    forever #5 mclk = ~mclk;
  end

  pdm_top #(.STEPS_PER_REV(50)) dut_u (
    .mclk(mclk),
    .resetn(resetn),
    .ce(ce),
    .addr(addr),
    .wdata(wdata),
    .wr_en(wr_en),
    .rd_en(rd_en),
    .rdata(rdata),
    .step(step),
    .dir_neg(dir_neg),
    .motor_stopped(stopped),
    .motor_energized(energized),
    .act_pos(act_pos),
    .hold_input(hold_in),
    .alarm_clear_input(clr_in),
    .hold_active(hold_active),
    .alarm_code_read(alarm_code),
    .alarm_active(alarm_active),
    .irq(irq)
  );

  pdm_motor_model motor_u (
    .mclk(mclk),
    .resetn(resetn),
    .step(step && ce),
    .dir_neg(dir_neg),
    .lag(lag),
    .act_pos(act_pos)
  );

  task automatic summarize();
    if (fail_count == 0 && tests_run > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask

  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    tests_run++;
    if (seen !== exp) begin
      fail_count++;
      $display("CHECK FAILED t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask

  task automatic cyc(input int k);
    repeat (k) @(posedge mclk);
  endtask

  task automatic wr(input logic [3:0] a, input logic [31:0] d);
    @(posedge mclk);
    addr <= a;
    wdata <= d;
    wr_en <= 1'b1;
    @(posedge mclk);
    wr_en <= 1'b0;
  endtask

  // Expectation is queued at the strobe; the monitor pops it one cycle on
  task automatic rd(input logic [3:0] a, input logic [31:0] e);
    @(posedge mclk);
    addr <= a;
    rd_en <= 1'b1;
    exp_q.push_back(e);
    @(posedge mclk);
    rd_en <= 1'b0;
  endtask

  always @(posedge mclk) begin
    if (rd_seen) begin
      chk(rdata, exp_q.pop_front());
    end
    rd_seen <= rd_en;
  end

  initial begin
    #100000;
    fail_count++;
    summarize();
  end

  initial begin
    void'($urandom(12778));
    cyc(6);
    resetn <= 1'b1;
    rd(`PDM_OFF_LIMIT, 32'h00000096);
    rd(`PDM_OFF_POSITION, 32'h00000000);
    wr(`PDM_OFF_LIMIT, 32'h00000064);
    rd(`PDM_OFF_LIMIT, 32'h00000064);
    wr(`PDM_OFF_LIMIT, 32'h00000000);
    wr(`PDM_OFF_LIMIT, 32'h00007531);
    rd(`PDM_OFF_LIMIT, 32'h00000064);
    rd(`PDM_OFF_STATUS, 32'h00000004);
    wr(`PDM_OFF_LIMIT, 32'h00007530);
    rd(`PDM_OFF_LIMIT, 32'h00007530);
    wr(`PDM_OFF_STATUS, 32'h00000004);
    rd(4'hf, 32'h00000000);
    wr(`PDM_OFF_POLARITY, 32'h00000001);
    hold_in <= 1'($urandom);
    cyc(1);
    #1 chk(hold_active, !hold_in);
    rd(`PDM_OFF_POLARITY, 32'h00000000);
    wr(`PDM_OFF_POLARITY, 32'h00000000);
    #1 chk(hold_active, hold_in);
    // Written limits of 100 and 30000 must not replace the boot value
    @(posedge mclk);
    lag <= 24'h000096;
    cyc(4);
    #1 chk(alarm_code, 8'h00);
    @(posedge mclk);
    lag <= 24'h000097;
    cyc(4);
    #1 chk(alarm_code, 8'h10);
    chk(alarm_active, 1'b1);
    chk(irq, 1'b0);
    wr(`PDM_OFF_MASK, 32'h00000001);
    #1 chk(irq, 1'b1);
    @(posedge mclk);
    lag <= 24'h000000;
    cyc(2);
    clr_in <= 1'b1;
    @(posedge mclk);
    clr_in <= 1'b0;
    cyc(3);
    #1 chk(alarm_code, 8'h00);
    rd(`PDM_OFF_POSITION, 32'h00000000);
    wr(`PDM_OFF_STATUS, 32'h00000001);
    #1 chk(irq, 1'b0);
    n = $urandom_range(8, 1);
    @(posedge mclk);
    step <= 1'b1;
    cyc(n);
    step <= 1'b0;
    rd(`PDM_OFF_POSITION, 32'(n));
    // Steps offered while the clock enable is low must be lost
    ce <= 1'b0;
    step <= 1'b1;
    cyc(3);
    step <= 1'b0;
    ce <= 1'b1;
    rd(`PDM_OFF_POSITION, 32'(n));
    // Host breaks the state rule here on purpose
    stopped <= 1'b0;
    wr(`PDM_OFF_POSITION, 32'h00000123);
    rd(`PDM_OFF_POSITION, 32'(n));
    rd(`PDM_OFF_STATUS, 32'h00000002);
    stopped <= 1'b1;
    energized <= 1'b0;
    wr(`PDM_OFF_POSITION, 32'h00000123);
    rd(`PDM_OFF_POSITION, 32'(n));
    energized <= 1'b1;
    wr(`PDM_OFF_POSITION, 32'h00800000);
    // Shaft starts three steps above the floor to keep the gap small
    lag <= 24'h7ffffd + 24'(n);
    rd(`PDM_OFF_POSITION, 32'hff800000);
    dir_neg <= 1'b1;
    @(posedge mclk);
    step <= 1'b1;
    cyc(3);
    step <= 1'b0;
    rd(`PDM_OFF_POSITION, 32'hff800000);
    #1 chk(alarm_code, 8'h00);
    cyc(2);
    summarize();
  end
endmodule
